// ==== verilog/msp_consts.svh ====
// constants for the stop, pause and stop-notify command block
// assumes inclusion by bare name from the design file
`ifndef MSP_CONSTS_SVH
`define MSP_CONSTS_SVH
`define MSP_NCH      16
`define MSP_NNET     3
`define MSP_SPD_MIN  24'h000005
`define MSP_SPD_MAX  24'h989680
`define MSP_SRQ_BYTE 8'h10
`define MSP_MAP_ALL  16'hffff
`define MSP_MAP_NONE 16'h0000
`endif

// ==== verilog/msp_pkg.sv ====
// types for the stop, pause and stop-notify command block
// assumes commands arrive already parsed from the text link
package msp_pkg;
	// parsed command opcodes
	typedef enum logic [4:0] {
		MSP_OP_NOP, MSP_OP_CH_SOFT, MSP_OP_CH_HARD, MSP_OP_ALL_SOFT,
		MSP_OP_ALL_HARD, MSP_OP_SPEED, MSP_OP_PAUSE_ON, MSP_OP_PAUSE_OFF,
		MSP_OP_PAUSE_Q, MSP_OP_REQ_Q, MSP_OP_GFLAG, MSP_OP_GFLAG_CLR,
		MSP_OP_GFLAG_Q, MSP_OP_GFLAG_QALL, MSP_OP_NFLAG, MSP_OP_NFLAG_CLR,
		MSP_OP_NFLAG_Q, MSP_OP_NFLAG_QALL
	} msp_op_t;
	// interface a command came in on; serial uses the serial prefix
	typedef enum logic [1:0] {
		MSP_IF_GPIB, MSP_IF_FAST, MSP_IF_NORM, MSP_IF_SER
	} msp_if_t;
	typedef enum logic [1:0] {
		MSP_RP_ONOFF, MSP_RP_BIT, MSP_RP_MAP
	} msp_rkind_t;
	typedef struct packed {
		msp_op_t     op;
		msp_if_t     src;
		logic [3:0]  ch;
		logic        arg;
		logic [2:0]  port;
		logic [23:0] pps;
	} msp_cmd_t;
	typedef struct packed {
		msp_rkind_t  kind;
		logic [15:0] data;
	} msp_reply_t;
	typedef struct packed {
		msp_if_t     dst;
		logic [2:0]  port;
		logic [3:0]  ch;
	} msp_msg_t;
	typedef struct packed {
		logic [3:0]  ch;
		logic [23:0] pps;
	} msp_speed_t;
endpackage : msp_pkg

// ==== verilog/msp_core.sv ====
// stop, speed change, pause and stop-notify command handling, 16 channels
// assumes a parser hands over one command per cycle and motion logic
// reports per-channel moving levels and new move requests
`timescale 1ns/1ps
`include "msp_consts.svh"

module msp_core (
	input  wire logic            ref_clk_in,      // 100 MHz clock
	input  wire logic            nrst_in,         // async reset, low
	input  wire logic            cmd_valid_in,    // parsed command strobe
	input  wire msp_pkg::msp_cmd_t cmd_in,        // parsed command
	input  wire logic            remote_in,       // remote mode level
	input  wire logic [15:0]     moving_in,       // motor moving per ch
	input  wire logic [15:0]     motion_req_in,   // new move request pulses
	output logic [15:0]          soft_stop_out,   // decelerating stop pulse
	output logic [15:0]          hard_stop_out,   // immediate stop pulse
	output logic [15:0]          start_out,       // move start pulses
	output logic [15:0]          standby_out,     // channels in standby
	output logic                 paused_out,      // pause state
	output logic                 speed_valid_out, // speed change pulse
	output msp_pkg::msp_speed_t  speed_out,       // channel and new speed
	output logic                 reply_valid_out, // reply pulse
	output msp_pkg::msp_reply_t  reply_out,       // reply payload
	output logic                 requesting_channel_query,         // GPIB service request
	output logic [7:0]           poll_byte_out,   // serial poll status
	output logic                 msg_valid_out,   // stop message pulse
	output msp_pkg::msp_msg_t    msg_out          // stop message target
);
	import msp_pkg::*;

	// one-hot decode of a channel number
	function automatic logic [15:0] ch_bit(input logic [3:0] ch);
		ch_bit = 16'h0001 << ch;
	endfunction : ch_bit

	// lowest set channel of a map
	function automatic logic [3:0] low_ch(input logic [15:0] m);
		low_ch = 4'h0;
		for (int i = `MSP_NCH - 1; i >= 0; i--) begin
			if (m[i]) begin
				low_ch = 4'(i);
			end
		end
	endfunction : low_ch

	logic [15:0] moving_q;
	logic [15:0] gflag;
	logic [15:0] req_map;
	logic [15:0] held;
	logic [15:0] nflag [`MSP_NNET];
	logic [15:0] npend [`MSP_NNET];
	logic [2:0]  nport [`MSP_NNET];
	logic [15:0] next_gflag;
	logic [15:0] next_req;
	logic [15:0] next_held;
	logic [15:0] next_start;
	logic [15:0] next_nflag [`MSP_NNET];
	logic [15:0] next_npend [`MSP_NNET];
	logic [2:0]  next_nport [`MSP_NNET];
	msp_reply_t  next_reply;
	logic        next_rvalid;

	// command decode; each accept term already folds in its mode checks
	wire [15:0] stopped  = moving_q & ~moving_in;
	wire [15:0] cmd_bit  = ch_bit(cmd_in.ch);
	wire        ch_moves = |(moving_in & cmd_bit);
	wire        is_net   = cmd_in.src != MSP_IF_GPIB;
	wire [1:0]  net_idx  = 2'(cmd_in.src) - 2'h1;
	wire        spd_ok   = cmd_in.pps >= `MSP_SPD_MIN &&
	                       cmd_in.pps <= `MSP_SPD_MAX;
	wire        op_soft  = cmd_valid_in && cmd_in.op == MSP_OP_CH_SOFT;
	wire        op_hard  = cmd_valid_in && cmd_in.op == MSP_OP_CH_HARD;
	wire        op_asoft = cmd_valid_in && cmd_in.op == MSP_OP_ALL_SOFT;
	wire        op_ahard = cmd_valid_in && cmd_in.op == MSP_OP_ALL_HARD;
	wire        op_speed = cmd_valid_in && cmd_in.op == MSP_OP_SPEED &&
	                       remote_in && ch_moves && spd_ok;
	wire        op_p_on  = cmd_valid_in && cmd_in.op == MSP_OP_PAUSE_ON &&
	                       remote_in;
	wire        op_p_off = cmd_valid_in && cmd_in.op == MSP_OP_PAUSE_OFF &&
	                       remote_in;
	wire        op_req_q = cmd_valid_in && cmd_in.op == MSP_OP_REQ_Q;
	wire        op_gflag = cmd_valid_in && cmd_in.op == MSP_OP_GFLAG;
	wire        op_gclr  = cmd_valid_in && cmd_in.op == MSP_OP_GFLAG_CLR;
	wire        op_nflag = cmd_valid_in && cmd_in.op == MSP_OP_NFLAG &&
	                       is_net;
	wire        op_nclr  = cmd_valid_in && cmd_in.op == MSP_OP_NFLAG_CLR &&
	                       is_net;

	// stop masks; stops never depend on remote mode
	wire [15:0] soft_m = op_asoft ? `MSP_MAP_ALL :
	                     (op_soft ? cmd_bit : `MSP_MAP_NONE);
	wire [15:0] hard_m = op_ahard ? `MSP_MAP_ALL :
	                     (op_hard ? cmd_bit : `MSP_MAP_NONE);

	// message scheduler: fast LAN first, then normal LAN, then serial
	wire       sel_v = |npend[0] || |npend[1] || |npend[2];
	wire [1:0] sel_i = |npend[0] ? 2'h0 : (|npend[1] ? 2'h1 : 2'h2);
	wire [3:0] sel_c = low_ch(npend[sel_i]);

	// GPIB flags and requesting map
	always_comb begin
		next_req = req_map;
		if (op_req_q) begin
			next_req = `MSP_MAP_NONE;
		end
		next_req = next_req | (stopped & gflag);
		next_gflag = gflag & ~stopped;
		if (op_gclr) begin
			next_gflag = `MSP_MAP_NONE;
		end else if (op_gflag && cmd_in.arg) begin
			next_gflag = next_gflag | cmd_bit;
		end else if (op_gflag) begin
			next_gflag = next_gflag & ~cmd_bit;
		end
	end

	// network flag sets, one per link class, never crossing
	always_comb begin
		for (int i = 0; i < `MSP_NNET; i++) begin
			next_npend[i] = npend[i];
			if (sel_v && sel_i == 2'(i)) begin
				next_npend[i] = npend[i] & ~ch_bit(sel_c);
			end
			next_npend[i] = next_npend[i] | (stopped & nflag[i]);
			next_nflag[i] = nflag[i] & ~stopped;
			next_nport[i] = nport[i];
			if (net_idx == 2'(i)) begin
				if (op_nclr) begin
					next_nflag[i] = `MSP_MAP_NONE;
				end else if (op_nflag && cmd_in.arg) begin
					next_nflag[i] = next_nflag[i] | cmd_bit;
					next_nport[i] = cmd_in.port;
				end else if (op_nflag) begin
					next_nflag[i] = next_nflag[i] & ~cmd_bit;
				end
			end
		end
	end

	// pause: requests are held in standby, released together
	always_comb begin
		next_held  = `MSP_MAP_NONE;
		next_start = motion_req_in;
		if (paused_out) begin
			next_held  = (held | motion_req_in) & ~(soft_m | hard_m);
			next_start = `MSP_MAP_NONE;
			if (op_p_off) begin
				next_start = held | motion_req_in;
				next_held  = `MSP_MAP_NONE;
			end
		end
	end

	// query replies
	always_comb begin
		next_rvalid = cmd_valid_in;
		next_reply  = '{kind: MSP_RP_MAP, data: `MSP_MAP_NONE};
		case (cmd_in.op)
			MSP_OP_PAUSE_Q: begin
				next_reply.kind = MSP_RP_ONOFF;
				next_reply.data = {15'h0000, paused_out};
			end
			MSP_OP_REQ_Q: begin
				next_reply.data = req_map;
			end
			MSP_OP_GFLAG_Q: begin
				next_reply.kind = MSP_RP_BIT;
				next_reply.data = {15'h0000, |(gflag & cmd_bit)};
			end
			MSP_OP_GFLAG_QALL: begin
				next_reply.data = gflag;
			end
			MSP_OP_NFLAG_Q: begin
				next_reply.kind = MSP_RP_BIT;
				next_reply.data = {15'h0000, |(nflag[net_idx] & cmd_bit)};
				next_rvalid     = cmd_valid_in && is_net;
			end
			MSP_OP_NFLAG_QALL: begin
				next_reply.data = nflag[net_idx];
				next_rvalid     = cmd_valid_in && is_net;
			end
			default: begin
				next_rvalid = 1'b0;
			end
		endcase
	end

	// flag and pause state
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			moving_q    <= `MSP_MAP_NONE;
			gflag       <= `MSP_MAP_NONE;
			req_map     <= `MSP_MAP_NONE;
			held        <= `MSP_MAP_NONE;
			paused_out  <= 1'b0;
			standby_out <= `MSP_MAP_NONE;
			for (int i = 0; i < `MSP_NNET; i++) begin
				nflag[i] <= `MSP_MAP_NONE;
				npend[i] <= `MSP_MAP_NONE;
				nport[i] <= 3'h0;
			end
		end else begin
			moving_q <= moving_in;
			gflag    <= next_gflag;
			req_map  <= next_req;
			held     <= next_held;
			nflag    <= next_nflag;
			npend    <= next_npend;
			nport    <= next_nport;
			if (op_p_on) begin
				paused_out  <= 1'b1;
				standby_out <= ~moving_in;
			end else if (op_p_off) begin
				paused_out  <= 1'b0;
				standby_out <= `MSP_MAP_NONE;
			end
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			soft_stop_out   <= `MSP_MAP_NONE;
			hard_stop_out   <= `MSP_MAP_NONE;
			start_out       <= `MSP_MAP_NONE;
			speed_valid_out <= 1'b0;
			speed_out       <= '0;
			reply_valid_out <= 1'b0;
			reply_out       <= '0;
			requesting_channel_query         <= 1'b0;
			poll_byte_out   <= 8'h00;
			msg_valid_out   <= 1'b0;
			msg_out         <= '0;
		end else begin
			soft_stop_out   <= soft_m;
			hard_stop_out   <= hard_m;
			start_out       <= next_start;
			speed_valid_out <= op_speed;
			speed_out       <= '{ch: cmd_in.ch, pps: cmd_in.pps};
			reply_valid_out <= next_rvalid;
			reply_out       <= next_reply;
			requesting_channel_query         <= |next_req;
			poll_byte_out   <= |next_req ? `MSP_SRQ_BYTE : 8'h00;
			msg_valid_out   <= sel_v;
			msg_out         <= '{dst: msp_if_t'(sel_i + 2'h1),
			                     port: nport[sel_i], ch: sel_c};
		end
	end

	// assertions share one clock and drop out during reset
	default clocking ast_cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!nrst_in);

	// stops hit the addressed channel in any mode, all forms cover 16
	AST_HARD_STOP: assert property (
		op_hard |=> hard_stop_out == ch_bit($past(cmd_in.ch)))
		else $error("channel hard stop not issued");
	AST_LOCAL_STOP: assert property (
		op_soft && !remote_in |=>
		soft_stop_out == ch_bit($past(cmd_in.ch)))
		else $error("soft stop dropped in local mode");
	AST_ALL_SOFT: assert property (
		op_asoft |=> soft_stop_out == `MSP_MAP_ALL)
		else $error("all soft stop missed a channel");
	AST_ALL_HARD: assert property (
		op_ahard |=> hard_stop_out == `MSP_MAP_ALL)
		else $error("all hard stop missed a channel");

	// speed change only when allowed and in range
	AST_SPEED: assert property (
		speed_valid_out |-> speed_out.pps >= `MSP_SPD_MIN &&
		speed_out.pps <= `MSP_SPD_MAX && $past(remote_in))
		else $error("speed change outside range or mode");
	AST_SPD_LOCAL: assert property (
		cmd_valid_in && cmd_in.op == MSP_OP_SPEED && !remote_in |=>
		!speed_valid_out)
		else $error("speed change taken in local mode");

	// pause: standby capture, hold and synchronous release
	AST_STANDBY: assert property (
		op_p_on |=> paused_out && standby_out == ~$past(moving_in))
		else $error("standby map not taken at pause on");
	AST_HOLD: assert property (
		paused_out && !op_p_off |=> start_out == `MSP_MAP_NONE)
		else $error("move started during standby");
	AST_SYNC: assert property (
		paused_out && op_p_off |=> !paused_out &&
		start_out == ($past(held) | $past(motion_req_in)))
		else $error("held moves not released together");
	AST_PAUSE_Q: assert property (
		cmd_valid_in && cmd_in.op == MSP_OP_PAUSE_Q |=> reply_valid_out &&
		reply_out.data[0] == $past(paused_out))
		else $error("pause query answer wrong");

	// notification: request, poll byte, queries and clears
	AST_POLL: assert property (
		poll_byte_out == (requesting_channel_query ? `MSP_SRQ_BYTE : 8'h00))
		else $error("poll byte does not follow service request");
	AST_NOTIFY: assert property (
		|(stopped & gflag) && !op_gflag |=>
		requesting_channel_query && ~|(gflag & $past(stopped)))
		else $error("flagged stop gave no request or kept flag");
	AST_REQ_MAP: assert property (
		op_req_q |=> reply_valid_out && reply_out.data == $past(req_map))
		else $error("requesting map reply wrong");
	AST_REQ_CLR: assert property (
		op_req_q && ~|(stopped & gflag) |=> !requesting_channel_query)
		else $error("request map not cleared by read");
	AST_GCLR: assert property (
		op_gclr |=> gflag == `MSP_MAP_NONE)
		else $error("group clear left a flag set");
	AST_NET_GPIB: assert property (
		cmd_valid_in && cmd_in.op == MSP_OP_NFLAG_Q && !is_net |=>
		!reply_valid_out)
		else $error("network query answered on the instrument bus");
endmodule : msp_core

// ==== verif/msp_host.sv ====
// host model: hands the block one parsed command per call
// assumes the bench calls send only after reset has been released
`timescale 1ns/1ps

module msp_host (
	input  wire logic         clk_in,    // bench clock
	output logic              valid_out, // command strobe
	output msp_pkg::msp_cmd_t cmd_out    // command fields
);
	import msp_pkg::*;

	// idle until the first command
	initial begin
		valid_out = 1'b0;
		cmd_out   = '0;
	end

	// strobe one edge, then scramble the fields so stale ones never pass
	task send(input msp_op_t op, input msp_if_t src, input logic [3:0] ch,
		input logic arg, input logic [2:0] port, input logic [23:0] pps);
		@(posedge clk_in);
		valid_out <= 1'b1;
		cmd_out   <= '{op, src, ch, arg, port, pps};
		@(posedge clk_in);
		valid_out <= 1'b0;
		cmd_out   <= ~cmd_out;
	endtask : send
endmodule : msp_host

// ==== verif/tb_top.sv ====
// bench for the stop, pause and stop-notify command block
// assumes commands, motion levels, move requests, remote mode and reset are the only stimulus
`timescale 1ns/1ps

module tb_top;
	import msp_pkg::*;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        remote = 1'b1;
	logic [15:0] moving = 16'h0000;
	logic [15:0] mreq = 16'h0000;
	logic        cmd_valid;
	msp_cmd_t    cmd;
	logic [15:0] soft_o, hard_o, start_o, stby_o, a_soft, a_hard, a_start;
	logic        paused_o, sv_o, rv_o, srq_o, mv_o, a_sv;
	logic [7:0]  poll_o;
	msp_speed_t  spd_o, a_spd;
	msp_reply_t  rep_o, a_rep;
	msp_msg_t    msg_o, a_msg, a_msg1;
	int          bad_count = 0, n_checks = 0, cyc = 0, n_rep, n_msg;

	always #5 ref_clk = ~ref_clk;

	msp_host host_u (.clk_in(ref_clk), .valid_out(cmd_valid), .cmd_out(cmd));
	msp_core dut_u (.ref_clk_in(ref_clk), .nrst_in(nrst),
		.cmd_valid_in(cmd_valid), .cmd_in(cmd), .remote_in(remote),
		.moving_in(moving), .motion_req_in(mreq), .soft_stop_out(soft_o),
		.hard_stop_out(hard_o), .start_out(start_o), .standby_out(stby_o),
		.paused_out(paused_o), .speed_valid_out(sv_o), .speed_out(spd_o),
		.reply_valid_out(rv_o), .reply_out(rep_o), .requesting_channel_query(srq_o),
		.poll_byte_out(poll_o), .msg_valid_out(mv_o), .msg_out(msg_o));

	// collect one-cycle pulses where they are settled
	always @(negedge ref_clk) begin
		a_soft  |= soft_o;
		a_hard  |= hard_o;
		a_start |= start_o;
		if (sv_o === 1'b1) begin
			a_sv  = 1'b1;
			a_spd = spd_o;
		end
		if (rv_o === 1'b1) begin
			n_rep++;
			a_rep = rep_o;
		end
		if (mv_o === 1'b1) begin
			if (n_msg == 0) begin
				a_msg1 = msg_o;
			end
			n_msg++;
			a_msg = msg_o;
		end
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			results();
		end
	end

	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task clr;
		a_soft = 16'h0000;
		a_hard = 16'h0000;
		a_start = 16'h0000;
		a_sv = 1'b0;
		n_rep = 0;
		n_msg = 0;
	endtask : clr

	task go(input msp_op_t op, input msp_if_t src = MSP_IF_GPIB,
		input logic [3:0] ch = 4'h0, input logic arg = 1'b0,
		input logic [2:0] port = 3'h0, input logic [23:0] pps = 24'h0);
		host_u.send(op, src, ch, arg, port, pps);
		clr();
		repeat (3) @(negedge ref_clk);
	endtask : go

	// new motion levels; a falling bit is a stop event
	task motion(input logic [15:0] m, input logic [15:0] req);
		clr();
		@(posedge ref_clk);
		moving <= m;
		mreq <= req;
		@(posedge ref_clk);
		mreq <= 16'h0000;
		repeat (6) @(negedge ref_clk);
	endtask : motion

	// stops are taken in local mode too
	task t_stops;
		@(posedge ref_clk) remote <= 1'b0;
		go(MSP_OP_CH_SOFT, MSP_IF_GPIB, 4'h1);
		chk(a_soft, 16'h0002);
		chk(a_hard, 16'h0000);
		go(MSP_OP_CH_HARD, MSP_IF_GPIB, 4'h7);
		chk(a_hard, 16'h0080);
		go(MSP_OP_ALL_SOFT);
		chk(a_soft, 16'hffff);
		go(MSP_OP_ALL_HARD);
		chk(a_hard, 16'hffff);
		motion(16'h0002, 16'h0000);
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h1, 1'b0, 3'h0, 24'h00000a);
		chk(a_sv, 1'b0);
		go(MSP_OP_PAUSE_ON);
		chk(paused_o, 1'b0);
		@(posedge ref_clk) remote <= 1'b1;
	endtask : t_stops

	// speed limits are inclusive at both ends
	task t_speed;
		motion(16'h0002, 16'h0000);
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h1, 1'b0, 3'h0, 24'h000005);
		chk({a_sv, a_spd}, {1'b1, 4'h1, 24'h000005});
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h1, 1'b0, 3'h0, 24'h989680);
		chk({a_sv, a_spd}, {1'b1, 4'h1, 24'h989680});
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h1, 1'b0, 3'h0, 24'h000004);
		chk(a_sv, 1'b0);
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h1, 1'b0, 3'h0, 24'h989681);
		chk(a_sv, 1'b0);
		go(MSP_OP_SPEED, MSP_IF_GPIB, 4'h2, 1'b0, 3'h0, 24'h000064);
		chk(a_sv, 1'b0);
	endtask : t_speed

	task t_pause;
		motion(16'h0002, 16'h0008);
		chk(a_start, 16'h0008);
		go(MSP_OP_PAUSE_ON);
		chk({paused_o, stby_o}, {1'b1, 16'hfffd});
		motion(16'h0002, 16'h0010);
		chk(a_start, 16'h0000);
		go(MSP_OP_PAUSE_Q);
		chk({n_rep, a_rep.kind, a_rep.data[0]},
			{32'd1, MSP_RP_ONOFF, 1'b1});
		go(MSP_OP_PAUSE_OFF);
		chk({paused_o, a_start}, {1'b0, 16'h0010});
		go(MSP_OP_PAUSE_Q);
		chk(a_rep.data[0], 1'b0);
	endtask : t_pause

	task t_gpib;
		motion(16'h0203, 16'h0000);
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h9, 1'b1);
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h0, 1'b1);
		go(MSP_OP_GFLAG_Q, MSP_IF_GPIB, 4'h9);
		chk({a_rep.kind, a_rep.data[0]}, {MSP_RP_BIT, 1'b1});
		go(MSP_OP_GFLAG_QALL);
		chk(a_rep.data, 16'h0201);
		motion(16'h0002, 16'h0000);
		chk({srq_o, poll_o}, {1'b1, 8'h10});
		go(MSP_OP_GFLAG_QALL);
		chk(a_rep.data, 16'h0000);
		go(MSP_OP_REQ_Q);
		chk({a_rep.kind, a_rep.data}, {MSP_RP_MAP, 16'h0201});
		chk({srq_o, poll_o}, {1'b0, 8'h00});
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h3, 1'b1);
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h5, 1'b1);
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h5, 1'b0);
		go(MSP_OP_GFLAG_QALL);
		chk(a_rep.data, 16'h0008);
		go(MSP_OP_GFLAG_CLR);
		go(MSP_OP_GFLAG_QALL);
		chk(a_rep.data, 16'h0000);
	endtask : t_gpib

	// the later set on a link moves that link's message port
	task t_net;
		go(MSP_OP_NFLAG, MSP_IF_FAST, 4'h1, 1'b1, 3'h5);
		go(MSP_OP_NFLAG, MSP_IF_FAST, 4'h1, 1'b1, 3'h2);
		go(MSP_OP_NFLAG, MSP_IF_NORM, 4'h1, 1'b1, 3'h1);
		go(MSP_OP_NFLAG_QALL, MSP_IF_FAST);
		chk(a_rep.data, 16'h0002);
		go(MSP_OP_NFLAG_QALL, MSP_IF_SER);
		chk(a_rep.data, 16'h0000);
		go(MSP_OP_NFLAG_Q, MSP_IF_NORM, 4'h1);
		chk(a_rep.data[0], 1'b1);
		go(MSP_OP_NFLAG_Q, MSP_IF_GPIB, 4'h1);
		chk(n_rep, 32'd0);
		motion(16'h0000, 16'h0000);
		chk(n_msg, 32'd2);
		chk(a_msg1, {MSP_IF_FAST, 3'h2, 4'h1});
		chk(a_msg, {MSP_IF_NORM, 3'h1, 4'h1});
		go(MSP_OP_NFLAG_QALL, MSP_IF_FAST);
		chk(a_rep.data, 16'h0000);
		go(MSP_OP_NFLAG, MSP_IF_SER, 4'h3, 1'b1);
		go(MSP_OP_NFLAG_Q, MSP_IF_SER, 4'h3);
		chk(a_rep.data[0], 1'b1);
		go(MSP_OP_NFLAG_CLR, MSP_IF_SER);
		go(MSP_OP_NFLAG_QALL, MSP_IF_SER);
		chk(a_rep.data, 16'h0000);
	endtask : t_net

	// a mid-run reset drops pause, standby and the GPIB flags
	task t_reset;
		go(MSP_OP_PAUSE_ON);
		go(MSP_OP_GFLAG, MSP_IF_GPIB, 4'h4, 1'b1);
		@(posedge ref_clk) nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(negedge ref_clk);
		chk({paused_o, stby_o, srq_o}, 18'h00000);
		go(MSP_OP_GFLAG_QALL);
		chk(a_rep.data, 16'h0000);
		motion(16'h0000, 16'h0020);
		chk(a_start, 16'h0020);
	endtask : t_reset

	task results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results

	// reset for four cycles, then every scenario in turn
	initial begin
		repeat (4) @(posedge ref_clk);
		nrst <= 1'b1;
		t_stops();
		t_speed();
		t_pause();
		t_gpib();
		t_net();
		t_reset();
		results();
	end
endmodule : tb_top
